// [rtl/mrms_defs.svh]
// constants for the rtu monitor slave: offsets, codes, defaults, timing
// assumes a single system clock; included by bare name
`ifndef MRMS_DEFS_SVH
`define MRMS_DEFS_SVH
`define MRMS_CLK_HZ          25000000
`define MRMS_BAUD_0          1200
`define MRMS_BAUD_1          2400
`define MRMS_BAUD_2          4800
`define MRMS_BAUD_3          9600
`define MRMS_BAUD_4          19200
`define MRMS_CHAR_BITS       11
`define MRMS_T35_HALF_CHARS  7
`define MRMS_T35_BITS        ((`MRMS_T35_HALF_CHARS * `MRMS_CHAR_BITS + 1) / 2)
`define MRMS_FUNC_RD_INPUT   8'h04
`define MRMS_EXC_FLAG        8'h80
`define MRMS_EXC_FUNC        8'h01
`define MRMS_EXC_ADDR        8'h02
`define MRMS_EXC_VALUE       8'h03
`define MRMS_REG_READING     16'h0000
`define MRMS_REG_ERRORS      16'h0007
`define MRMS_REG_DECIMAL     16'h0008
`define MRMS_REQ_LEN         4'h8
`define MRMS_MIN_LEN         4'h4
`define MRMS_ADDR_MIN        8'h01
`define MRMS_ADDR_MAX        8'hF7
`define MRMS_BAUD_MAX        3'h4
`define MRMS_PAR_MAX         2'h2
`define MRMS_PAR_ODD         2'h1
`define MRMS_DEF_ADDR        8'h01
`define MRMS_DEF_BAUD        3'h3
`define MRMS_DEF_PARITY      2'h0
`define MRMS_DEF_STOP        1'h0
`define MRMS_DEF_DP          2'h1
`define MRMS_DEF_LIMIT_LO    16'hFC18
`define MRMS_DEF_LIMIT_HI    16'h00C8
`define MRMS_DEF_AL1_TYPE    1'h1
`define MRMS_DEF_AL2_TYPE    1'h0
`define MRMS_DEF_OUT_RANGE   1'h1
`define MRMS_PPM_ZERO_LO_UA  16'h0BB8
`define MRMS_PPM_ZERO_HI_UA  16'h0FA0
`define MRMS_CRC_INIT        16'hFFFF
`define MRMS_CRC_POLY        16'hA001
`endif

// [rtl/mrms_pkg.sv]
// types for the rtu monitor slave: states, unit codes and the state record
// assumes nothing beyond a single clock domain
package mrms_pkg;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RX   = 2'b01,
      S_EXEC = 2'b10,
      S_TX   = 2'b11
   } mrms_state_e_t;
   typedef enum logic [1:0] {
      UNIT_CELSIUS = 2'b00,
      UNIT_FAHR    = 2'b01,
      UNIT_PPM     = 2'b10
   } mrms_unit_t;
   typedef struct packed {
      mrms_state_e_t   st;
      logic [2:0]      sync;
      logic            rxf;
      logic [15:0]     cnt;
      logic [3:0]      bitn;
      logic [7:0]      sh;
      logic [7:0][7:0] rbuf;
      logic [3:0]      rlen;
      logic            rbad;
      logic [15:0]     crc;
      logic [23:0]     idle;
      logic [6:0][7:0] tbuf;
      logic [3:0]      tlen;
      logic [3:0]      tpos;
      logic            tx;
      logic            de;
      logic [7:0]      addr;
      logic [2:0]      baud;
      logic [1:0]      par;
      logic            stop;
      logic [1:0]      dp;
      mrms_unit_t      unit;
      logic [15:0]     lo;
      logic [15:0]     hi;
      logic [15:0]     amin;
      logic [15:0]     amax;
      logic            a1t;
      logic            a2t;
      logic            orng;
      logic [15:0]     disp;
      logic [2:0]      err;
      logic            flash;
      logic            ledc;
      logic            ledf;
      logic            al1;
      logic            al2;
   } mrms_state_t;
endpackage

// [rtl/mrms_slave.sv]
// rtu slave of a panel monitor: serial receive, request decode, reply, display logic
// assumes rx_i comes from an rs485 receiver pin; all other inputs are on clk_i
//
// Functional notes
// [R1] node address 1..247, default 1; only frames with our address are served
// [R2] baud code 0..4 selects 1200,2400,4800,9600,19200; other codes refused
// [R3] after reset baud code is 3, link runs at 9600
// [R4] parity code 0 none, 1 odd, 2 even; default 0
// [R5] stop code 0 one stop bit, 1 two stop bits; default 0
// [R6] eight data bits, no flow control; default no parity, one stop
// [R7] only function 4, read input register, is implemented
// [R8] every exposed value is a 16-bit read-only input register
// [R9] register 0 returns displayed reading as signed 16-bit, no decimal point
// [R10] negative readings are two's complement
// [R11] register 7: bit0 break, bit1 over-range, bit2 under-range, rest zero
// [R12] no fault reads 0; disconnected sensor reads 5
// [R13] register 8 returns decimal point selection 0..3
// [R14] reply: address, function, byte count twice registers, data high first, crc
// [R15] every frame ends with crc16 over preceding bytes
// [R16] ppm unit with loop current 3..4 mA shows and reports zero
// [R17] display flashes when reading leaves lower..upper range limits
// [R18] decimal position defaults to one digit; zero removes the point
// [R19] alarm set-points clamped to min/max alarm limits, defaults -100.0/020.0
// [R20] ppm unit lights neither celsius nor fahrenheit indicator
// [R21] alarm type 1 low, 0 high; alarm one low, alarm two high by default
// [R22] output range code 1 selects 4-20 mA (default), 0 selects 0-20 mA
// [R23] frames with bad crc or foreign address are dropped silently
// [R24] end of frame is line idle for at least 3.5 character times
// [R25] bad function or unmapped register gets an exception reply
`timescale 1ns/100ps
`default_nettype none
`include "mrms_defs.svh"
module mrms_slave
   import mrms_pkg::*;
#(
   parameter int CLK_HZ = `MRMS_CLK_HZ
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        rx_i,
   output logic             tx_o,
   output logic             de_o,
   input  wire logic        cfg_load_i,
   input  wire logic [7:0]  node_address_setting_i,
   input  wire logic [2:0]  baud_code_i,
   input  wire logic [1:0]  parity_code_i,
   input  wire logic        stop_bit_select_code_i,
   input  wire logic [1:0]  decimal_position_setting_i,
   input  wire logic [1:0]  unit_select_i,
   input  wire logic [15:0] lower_range_limit_i,
   input  wire logic [15:0] upper_range_limit_i,
   input  wire logic [15:0] min_alarm_level_limit_i,
   input  wire logic [15:0] max_alarm_level_limit_i,
   input  wire logic        alarm_one_type_i,
   input  wire logic        alarm_two_type_i,
   input  wire logic        output_range_code_i,
   input  wire logic [15:0] alarm_one_setpoint_i,
   input  wire logic [15:0] alarm_two_setpoint_i,
   input  wire logic [15:0] measured_value_i,
   input  wire logic [15:0] loop_current_ua_i,
   input  wire logic        sensor_break_flag_i,
   input  wire logic        over_range_i,
   input  wire logic        under_range_i,
   output logic [15:0]      display_value_o,
   output logic             display_flash_o,
   output logic [1:0]       decimal_point_o,
   output logic             led_celsius_o,
   output logic             led_fahrenheit_o,
   output logic             alarm_one_o,
   output logic             alarm_two_o,
   output logic             retrans_live_zero_o
);
   mrms_state_t q;
   mrms_state_t d;
   logic [15:0] bt;
   logic [3:0]  rx_last;
   logic [3:0]  tx_last;
   logic [23:0] t35;
   logic [15:0] start;
   logic [15:0] num;
   logic [15:0] sp1;
   logic [15:0] sp2;
   logic [7:0]  cur;
   logic        ppm_zero;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `MRMS_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [15:0] bit_cycles(input logic [2:0] code);
      case (code)
         3'h0:    return 16'(CLK_HZ / `MRMS_BAUD_0);
         3'h1:    return 16'(CLK_HZ / `MRMS_BAUD_1);
         3'h2:    return 16'(CLK_HZ / `MRMS_BAUD_2);
         3'h4:    return 16'(CLK_HZ / `MRMS_BAUD_4);
         default: return 16'(CLK_HZ / `MRMS_BAUD_3);
      endcase
   endfunction

   function automatic logic mapped(input logic [15:0] a);
      return a == `MRMS_REG_READING || a == `MRMS_REG_ERRORS || a == `MRMS_REG_DECIMAL;
   endfunction

   // every mapped value leaves as one 16-bit read-only word
   function automatic logic [15:0] reg_val(input logic [15:0] a); // [R8]
      if (a == `MRMS_REG_READING) begin
         return q.disp;                                        // [R9] [R10]
      end else if (a == `MRMS_REG_ERRORS) begin
         return {13'h0000, q.err};                             // [R11]
      end
      return {14'h0000, q.dp};                                 // [R13]
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      if ($signed(v) < $signed(lo)) begin
         return lo;
      end else if ($signed(v) > $signed(hi)) begin
         return hi;
      end
      return v;
   endfunction

   always_comb begin
      d        = q;
      bt       = bit_cycles(q.baud);
      rx_last  = 4'h9 + ((q.par != 2'h0) ? 4'h1 : 4'h0);
      tx_last  = rx_last + (q.stop ? 4'h1 : 4'h0);           // [R5]
      t35      = 24'(bt) * 24'(`MRMS_T35_BITS);              // [R24]
      start    = {q.rbuf[2], q.rbuf[3]};
      num      = {q.rbuf[4], q.rbuf[5]};
      cur      = (q.tpos < q.tlen) ? q.tbuf[q.tpos[2:0]]
               : ((q.tpos == q.tlen) ? q.crc[7:0] : q.crc[15:8]);
      d.sync   = {q.sync[1:0], rx_i};
      if (q.sync[2] == q.sync[1]) begin
         d.rxf = q.sync[2];
      end
      case (q.st)
         S_IDLE: begin
            d.de = 1'b0;
            d.tx = 1'b1;
            if (!q.rxf) begin
               d.st   = S_RX;
               d.cnt  = bt >> 1;
               d.bitn = 4'h0;
            end else if (q.rlen != 4'h0) begin
               d.idle = q.idle + 24'h000001;
               if (q.idle >= t35) begin                      // [R24]
                  d.st = S_EXEC;
               end
            end
         end
         S_RX: begin
            if (q.cnt != 16'h0000) begin
               d.cnt = q.cnt - 16'h0001;
            end else begin
               d.cnt  = bt - 16'h0001;
               d.bitn = q.bitn + 4'h1;
               if (q.bitn == 4'h0 && q.rxf) begin
                  d.st = S_IDLE;                             // false start, no byte
               end else if (q.bitn >= 4'h1 && q.bitn <= 4'h8) begin
                  d.sh = {q.rxf, q.sh[7:1]};                 // [R6]
               end else if (q.bitn == 4'h9 && q.par != 2'h0) begin
                  if (q.rxf != ((q.par == `MRMS_PAR_ODD) ? ~^q.sh : ^q.sh)) begin
                     d.rbad = 1'b1;                          // [R4]
                  end
               end
               if (q.bitn == rx_last) begin
                  if (!q.rxf || q.rlen >= `MRMS_REQ_LEN) begin
                     d.rbad = 1'b1;
                  end else begin
                     d.rbuf[q.rlen[2:0]] = q.sh;
                     d.rlen = q.rlen + 4'h1;
                  end
                  d.crc  = crc_byte(q.crc, q.sh);            // [R15]
                  d.idle = 24'h000000;
                  d.st   = S_IDLE;
               end
            end
         end
         S_EXEC: begin
            d.st      = S_IDLE;
            d.rlen    = 4'h0;
            d.rbad    = 1'b0;
            d.crc     = `MRMS_CRC_INIT;
            d.idle    = 24'h000000;
            d.tbuf    = '0;
            d.tbuf[0] = q.addr;
            d.tbuf[1] = q.rbuf[1];
            d.tpos    = 4'h0;
            d.bitn    = 4'h0;
            d.cnt     = bt - 16'h0001;
            d.tlen    = 4'h3;
            // silence unless crc residue is zero and the address is ours
            if (q.rlen >= `MRMS_MIN_LEN && !q.rbad && q.crc == 16'h0000
                && q.rbuf[0] == q.addr) begin                // [R1] [R23] [R15]
               d.st = S_TX;
               d.de = 1'b1;
               if (q.rbuf[1] != `MRMS_FUNC_RD_INPUT) begin   // [R7] [R25]
                  d.tbuf[1] = q.rbuf[1] | `MRMS_EXC_FLAG;
                  d.tbuf[2] = `MRMS_EXC_FUNC;
               end else if (q.rlen != `MRMS_REQ_LEN || num == 16'h0000) begin
                  d.tbuf[1] = q.rbuf[1] | `MRMS_EXC_FLAG;
                  d.tbuf[2] = `MRMS_EXC_VALUE;
               end else if (num == 16'h0001 && mapped(start)) begin
                  d.tbuf[2] = 8'h02;                         // [R14]
                  {d.tbuf[3], d.tbuf[4]} = reg_val(start);
                  d.tlen = 4'h5;
               end else if (num == 16'h0002 && mapped(start)
                            && mapped(start + 16'h0001)) begin
                  d.tbuf[2] = 8'h04;                         // [R14]
                  {d.tbuf[3], d.tbuf[4]} = reg_val(start);
                  {d.tbuf[5], d.tbuf[6]} = reg_val(start + 16'h0001);
                  d.tlen = 4'h7;
               end else begin                                // [R25]
                  d.tbuf[1] = q.rbuf[1] | `MRMS_EXC_FLAG;
                  d.tbuf[2] = `MRMS_EXC_ADDR;
               end
            end
         end
         S_TX: begin
            d.de = 1'b1;
            if (q.bitn == 4'h0) begin
               d.tx = 1'b0;
            end else if (q.bitn <= 4'h8) begin
               d.tx = cur[3'(q.bitn - 4'h1)];
            end else if (q.bitn == 4'h9 && q.par != 2'h0) begin
               d.tx = (q.par == `MRMS_PAR_ODD) ? ~^cur : ^cur;
            end else begin
               d.tx = 1'b1;
            end
            if (q.cnt != 16'h0000) begin
               d.cnt = q.cnt - 16'h0001;
            end else begin
               d.cnt  = bt - 16'h0001;
               d.bitn = q.bitn + 4'h1;
               if (q.bitn == tx_last) begin
                  d.bitn = 4'h0;
                  d.tpos = q.tpos + 4'h1;
                  if (q.tpos < q.tlen) begin
                     d.crc = crc_byte(q.crc, cur);           // [R15]
                  end
                  if (q.tpos == q.tlen + 4'h1) begin
                     d.st = S_IDLE;
                     d.de = 1'b0;
                     d.tx = 1'b1;
                     d.crc = `MRMS_CRC_INIT;
                  end
               end
            end
         end
         default: d.st = S_IDLE;
      endcase
      // settings: an out-of-range address, baud or parity code keeps its old value
      if (cfg_load_i) begin
         if (node_address_setting_i >= `MRMS_ADDR_MIN
             && node_address_setting_i <= `MRMS_ADDR_MAX) begin
            d.addr = node_address_setting_i;                 // [R1]
         end
         if (baud_code_i <= `MRMS_BAUD_MAX) begin
            d.baud = baud_code_i;                            // [R2]
         end
         if (parity_code_i <= `MRMS_PAR_MAX) begin
            d.par = parity_code_i;                           // [R4]
         end
         d.stop = stop_bit_select_code_i;                    // [R5]
         d.dp   = decimal_position_setting_i;                // [R18]
         d.unit = mrms_unit_t'(unit_select_i);
         d.lo   = lower_range_limit_i;
         d.hi   = upper_range_limit_i;
         d.amin = min_alarm_level_limit_i;
         d.amax = max_alarm_level_limit_i;
         d.a1t  = alarm_one_type_i;
         d.a2t  = alarm_two_type_i;
         d.orng = output_range_code_i;                       // [R22]
      end
      ppm_zero = q.unit == UNIT_PPM && loop_current_ua_i >= `MRMS_PPM_ZERO_LO_UA
                 && loop_current_ua_i < `MRMS_PPM_ZERO_HI_UA;
      d.disp  = ppm_zero ? 16'h0000 : measured_value_i;      // [R16]
      d.err   = {under_range_i | sensor_break_flag_i, over_range_i,
                 sensor_break_flag_i};                       // [R11] [R12]
      d.flash = $signed(q.disp) < $signed(q.lo)
                || $signed(q.disp) > $signed(q.hi);          // [R17]
      d.ledc  = q.unit == UNIT_CELSIUS;                      // [R20]
      d.ledf  = q.unit == UNIT_FAHR;
      sp1     = clamp(alarm_one_setpoint_i, q.amin, q.amax); // [R19]
      sp2     = clamp(alarm_two_setpoint_i, q.amin, q.amax);
      d.al1   = q.a1t ? $signed(q.disp) < $signed(sp1)
                      : $signed(q.disp) > $signed(sp1);      // [R21]
      d.al2   = q.a2t ? $signed(q.disp) < $signed(sp2)
                      : $signed(q.disp) > $signed(sp2);
      if (rst_i) begin
         d      = '0;
         d.st   = S_IDLE;
         d.sync = 3'h7;
         d.rxf  = 1'b1;
         d.tx   = 1'b1;
         d.crc  = `MRMS_CRC_INIT;
         d.addr = `MRMS_DEF_ADDR;                            // [R1]
         d.baud = `MRMS_DEF_BAUD;                            // [R3]
         d.par  = `MRMS_DEF_PARITY;                          // [R6]
         d.stop = `MRMS_DEF_STOP;
         d.dp   = `MRMS_DEF_DP;                              // [R18]
         d.unit = UNIT_CELSIUS;
         d.lo   = `MRMS_DEF_LIMIT_LO;
         d.hi   = `MRMS_DEF_LIMIT_HI;
         d.amin = `MRMS_DEF_LIMIT_LO;                        // [R19]
         d.amax = `MRMS_DEF_LIMIT_HI;
         d.a1t  = `MRMS_DEF_AL1_TYPE;                        // [R21]
         d.a2t  = `MRMS_DEF_AL2_TYPE;
         d.orng = `MRMS_DEF_OUT_RANGE;                       // [R22]
      end
   end

   always_ff @(posedge clk_i) begin
      q <= d;
   end

   assign tx_o                = q.tx;
   assign de_o                = q.de;
   assign display_value_o     = q.disp;
   assign display_flash_o     = q.flash;
   assign decimal_point_o     = q.dp;
   assign led_celsius_o       = q.ledc;
   assign led_fahrenheit_o    = q.ledf;
   assign alarm_one_o         = q.al1;
   assign alarm_two_o         = q.al2;
   assign retrans_live_zero_o = q.orng;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_exec_ours;
      q.st == S_EXEC && q.rlen == `MRMS_REQ_LEN && !q.rbad && q.crc == 16'h0000
      && q.rbuf[0] == q.addr;
   endsequence
   sequence s_exec_foreign;
      q.st == S_EXEC && q.rbuf[0] != q.addr;
   endsequence

   AST_ADDR_RANGE: assert property (q.addr >= `MRMS_ADDR_MIN && q.addr <= `MRMS_ADDR_MAX) // [R1]
      else $error("node address out of range");
   AST_BAUD_CODE: assert property (q.baud <= `MRMS_BAUD_MAX) // [R2]
      else $error("baud code out of range");
   AST_PARITY_CODE: assert property (q.par <= `MRMS_PAR_MAX) // [R4]
      else $error("parity code out of range");
   AST_RESET_DEFAULTS: assert property ($past(rst_i) |-> q.baud == `MRMS_DEF_BAUD // [R3]
      && q.addr == `MRMS_DEF_ADDR && q.par == `MRMS_DEF_PARITY && !q.stop
      && q.dp == `MRMS_DEF_DP) else $error("wrong settings after reset");
   AST_DISCONNECT: assert property (sensor_break_flag_i |=> q.err[0] && q.err[2]) // [R12]
      else $error("break does not report five");
   AST_PPM_ZERO: assert property (ppm_zero |=> display_value_o == 16'h0000) // [R16]
      else $error("ppm reading not zero in 3..4 mA");
   AST_PPM_LEDS: assert property (q.unit == UNIT_PPM |=> !led_celsius_o && !led_fahrenheit_o) // [R20]
      else $error("unit indicator lit in ppm");
   AST_FLASH_HIGH: assert property ($signed(q.disp) > $signed(q.hi) |=> display_flash_o) // [R17]
      else $error("no flash above upper limit");
   AST_DROP_FOREIGN: assert property (s_exec_foreign |=> !de_o [*2]) // [R23]
      else $error("reply to foreign frame");
   AST_REPLY_OURS: assert property (s_exec_ours |=> de_o && q.st == S_TX && q.tbuf[0] == q.addr) // [R14]
      else $error("no reply to own frame");
endmodule
`default_nettype wire

// [sim/mrms_master_model.sv]
// rtu master model: sends request characters on the slave's rx line, collects reply bytes
// assumes the bench sets bit time, parity and stop count to match the slave's settings
`timescale 1ns/100ps
`default_nettype none
module mrms_master_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] bit_cyc_i,
   input  wire logic [1:0]  par_i,
   input  wire logic        stop_i,
   input  wire logic        tx_i,
   input  wire logic        de_i,
   output logic             rx_o
);
   logic [7:0] rx_q[$];
   logic [7:0] b;
   // the bus bias holds the line high between characters
   initial rx_o = 1'b1;
   task automatic send_byte(input logic [7:0] d);
      @(posedge clk_i);
      rx_o <= 1'b0;
      repeat (bit_cyc_i) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         rx_o <= d[i];
         repeat (bit_cyc_i) @(posedge clk_i);
      end
      if (par_i != 2'h0) begin
         rx_o <= ^d ^ (par_i == 2'h1);
         repeat (bit_cyc_i) @(posedge clk_i);
      end
      rx_o <= 1'b1;
      repeat (bit_cyc_i * (stop_i + 1)) @(posedge clk_i);
   endtask
   // caller supplies address, function code and crc bytes already in place
   task automatic send_frame(input logic [7:0] q[$]);
      foreach (q[i]) send_byte(q[i]);
   endtask
   // parity bit of a reply is skipped, not judged; bytes are compared by the bench
   always begin
      @(negedge tx_i iff de_i);
      repeat (bit_cyc_i / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc_i) @(posedge clk_i);
         b[i] = tx_i;
      end
      repeat (bit_cyc_i * (par_i != 2'h0 ? 2 : 1)) @(posedge clk_i);
      rx_q.push_back(b);
   end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of the rtu monitor slave: reads, refusals, settings, display logic
// assumes the master model on the serial pins and a shortened clock parameter
`timescale 1ns/100ps
`default_nettype none
`include "mrms_defs.svh"
module tb_top;
   localparam int CLK = 160000;
   localparam int BR[5] = '{`MRMS_BAUD_0, `MRMS_BAUD_1, `MRMS_BAUD_2, `MRMS_BAUD_3, `MRMS_BAUD_4};
   localparam logic [7:0] AT[5] = '{8'hF7, 8'h05, 8'h09, 8'h11, 8'h01};
   logic        clk_i = 1'b0, rst_i = 1'b1, ld = 1'b0, rx, tx, de;
   logic [7:0]  ad = 8'h01;
   logic [2:0]  bd = 3'h3;
   logic [1:0]  pr = 2'h0, dp = 2'h1, un = 2'h0, pm = 2'h0, dpo;
   logic        sp = 1'b0, t1 = 1'b1, t2 = 1'b0, orng = 1'b1, sm = 1'b0;
   logic        brk = 1'b0, ovr = 1'b0, und = 1'b0, fl, lc, lf, a1, a2, rz;
   logic [15:0] lo = 16'hFC18, hi = 16'h00C8, sp1 = 16'h0000, sp2 = 16'h0000;
   logic [15:0] mv = 16'h0000, ua = 16'h0000, dv, bcyc = 16'(CLK / `MRMS_BAUD_3);
   logic [7:0]  exp_q[$];
   logic [31:0] xs = 32'hC6BF;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   mrms_slave #(.CLK_HZ(CLK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx), .tx_o(tx),
      .de_o(de), .cfg_load_i(ld), .node_address_setting_i(ad), .baud_code_i(bd),
      .parity_code_i(pr), .stop_bit_select_code_i(sp), .decimal_position_setting_i(dp),
      .unit_select_i(un), .lower_range_limit_i(lo), .upper_range_limit_i(hi),
      .min_alarm_level_limit_i(lo), .max_alarm_level_limit_i(hi), .alarm_one_type_i(t1),
      .alarm_two_type_i(t2), .output_range_code_i(orng), .alarm_one_setpoint_i(sp1),
      .alarm_two_setpoint_i(sp2), .measured_value_i(mv), .loop_current_ua_i(ua),
      .sensor_break_flag_i(brk), .over_range_i(ovr), .under_range_i(und),
      .display_value_o(dv), .display_flash_o(fl), .decimal_point_o(dpo),
      .led_celsius_o(lc), .led_fahrenheit_o(lf), .alarm_one_o(a1), .alarm_two_o(a2),
      .retrans_live_zero_o(rz));
   mrms_master_model u_m (.clk_i(clk_i), .bit_cyc_i(bcyc), .par_i(pm), .stop_i(sm),
      .tx_i(tx), .de_i(de), .rx_o(rx));
   initial forever #20 clk_i = ~clk_i;
   function automatic logic [15:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs[15:0];
   endfunction
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = `MRMS_CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `MRMS_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      n_checks++;
      if (got !== want) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // the model follows only settings the slave is expected to accept
   task automatic cfg(input logic [7:0] a, input logic [2:0] b, input logic [1:0] p, d,
                      input logic s);
      @(posedge clk_i);
      ad <= a;
      bd <= b;
      pr <= p;
      dp <= d;
      sp <= s;
      ld <= 1'b1;
      @(posedge clk_i);
      ld <= 1'b0;
      if (b <= `MRMS_BAUD_MAX) bcyc <= 16'(CLK / BR[b]);
      if (p <= `MRMS_PAR_MAX) pm <= p;
      sm <= s;
   endtask
   task automatic xact(input logic [7:0] rq[$], input logic [7:0] rp[$], input bit bad);
      logic [15:0] c;
      bit          saw;
      c = crc16(rq) ^ {15'h0000, bad};
      rq.push_back(c[7:0]);
      rq.push_back(c[15:8]);
      if (rp.size() > 0) begin
         c = crc16(rp);
         rp.push_back(c[7:0]);
         rp.push_back(c[15:8]);
      end
      exp_q = {exp_q, rp};
      u_m.send_frame(rq);
      saw = 1'b0;
      for (int i = 0; i < 50 * bcyc && !saw; i++) begin
         @(posedge clk_i);
         saw = (de === 1'b1);
      end
      for (int i = 0; i < 130 * bcyc && de !== 1'b0; i++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk(saw, rp.size() > 0);
      chk(exp_q.size(), 0);
   endtask
   always @(posedge clk_i) begin
      if (u_m.rx_q.size() > 0) begin
         chk({8'h00, u_m.rx_q.pop_front()}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF);
      end
   end
   // ceiling sits well above the longest expected run
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 100000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(dpo, `MRMS_DEF_DP);
      chk(rz, 1'b1);
      chk(crc16('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}), 16'hCA31);
      mv <= rnd() | 16'h8000;
      @(posedge clk_i);
      xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h04, 8'h02, mv[15:8], mv[7:0]}, 0);
      brk <= 1'b1;
      und <= 1'b1;
      xact('{8'h01, 8'h04, 8'h00, 8'h07, 8'h00, 8'h01}, '{8'h01, 8'h04, 8'h02, 8'h00, 8'h05}, 0);
      brk <= 1'b0;
      und <= 1'b0;
      ovr <= 1'b1;
      xact('{8'h01, 8'h04, 8'h00, 8'h07, 8'h00, 8'h02}, '{8'h01, 8'h04, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01}, 0);
      xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h83, 8'h01}, 0);
      xact('{8'h01, 8'h04, 8'h00, 8'h05, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h02}, 0);
      xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1);
      xact('{8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 0);
      cfg(8'hF8, 3'h5, 2'h3, 2'h1, 1'b0);
      xact('{8'h01, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, '{8'h01, 8'h04, 8'h02, 8'h00, 8'h01}, 0);
      for (int i = 0; i < 5; i++) begin
         cfg(AT[i], 3'((i + 4) % 5), 2'(i % 3), 2'(i), i[0]);
         xact('{AT[i], 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, '{AT[i], 8'h04, 8'h02, 8'h00, 8'(i % 4)}, 0);
      end
      chk(dpo, 2'h0);
      un <= 2'h2;
      orng <= 1'b0;
      cfg(8'h01, 3'h3, 2'h0, 2'h1, 1'b0);
      ua <= 16'h0DAC;
      mv <= 16'h0123;
      repeat (4) @(posedge clk_i);
      chk(dv, 16'h0000);
      chk({lc, lf}, 2'b00);
      chk(rz, 1'b0);
      ua <= `MRMS_PPM_ZERO_HI_UA;
      repeat (4) @(posedge clk_i);
      chk(dv, 16'h0123);
      chk(fl, 1'b1);
      sp1 <= 16'hF830;
      sp2 <= 16'h7000;
      mv <= 16'hFB50;
      repeat (4) @(posedge clk_i);
      chk({a1, a2, fl}, 3'b101);
      mv <= 16'h012C;
      repeat (4) @(posedge clk_i);
      chk({a1, a2}, 2'b01);
      mv <= hi;
      repeat (4) @(posedge clk_i);
      chk({a2, fl}, 2'b00);
      un <= 2'h1;
      cfg(8'h01, 3'h3, 2'h0, 2'h1, 1'b0);
      repeat (4) @(posedge clk_i);
      chk({lc, lf}, 2'b01);
      final_report();
   end
endmodule
`default_nettype wire
